// ===== host_byte_if.sv
// Carrier between the pin front end and the command decoder.
// Assumes both ends run on clk.
`timescale 1ns/1ns
interface host_byte_if;
   logic       wr_stb;
   logic       rd_stb;
   logic       sel;
   logic [7:0] data;

   modport front (output wr_stb, output rd_stb, output sel, output data);
   modport core  (input wr_stb, input rd_stb, input sel, input data);
endinterface : host_byte_if

// ===== host_model.sv
// Host processor model driving the parallel command port.
// Assumes the device takes a byte at the rising end of wr_b.
`timescale 1ns/1ns
module host_model (
   // Clock
   input  wire logic       clk,
   // Read side of the port
   input  wire logic [7:0] data_out,
   input  wire logic [7:0] data_oe,
   // Parallel port
   output logic            wr_b,
   output logic            rd_b,
   output logic            cmd_param_select,
   output logic [7:0]      data_in
);
   // No external supply is modelled, so discharge and power save need no switching
   initial begin
      wr_b             = 1'b1;
      rd_b             = 1'b1;
      cmd_param_select = 1'b0;
      data_in          = 8'h00;
   end

   // Byte write; data stands 6 clocks before the strobe end and 3 after
   task automatic put(input logic sel, input logic [7:0] b);
      @(posedge clk) #1;
      cmd_param_select = sel;
      data_in          = b;
      wr_b             = 1'b0;
      repeat (6) @(posedge clk);
      #1 wr_b = 1'b1;
      repeat (3) @(posedge clk);
      #1 data_in = ~b;
      repeat (4) @(posedge clk);
   endtask : put

   // Read cycle; data taken while the strobe is still low
   task automatic get(output logic [7:0] b, output logic [7:0] oe);
      @(posedge clk) #1;
      cmd_param_select = 1'b1;
      rd_b             = 1'b0;
      repeat (8) @(posedge clk);
      b  = data_out;
      oe = data_oe;
      #1 rd_b = 1'b1;
      repeat (4) @(posedge clk);
   endtask : get
endmodule : host_model

// ===== host_pin_sync.sv
// Synchronises the host strobes and turns the rising (end) edge of wr_b and the falling (start) edge of rd_b into pulses.
// Assumes data and select are stable around the end of each strobe.
`timescale 1ns/1ns
module host_pin_sync (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rst_b,
   // Host pins
   input  wire logic       wr_b,
   input  wire logic       rd_b,
   input  wire logic       cmd_param_select,
   input  wire logic [7:0] data_in,
   // Toward the decoder
   host_byte_if.front      hb
);
   logic [2:0] wr_sh_ff;
   logic [2:0] rd_sh_ff;
   logic [2:0] sel_sh_ff;
   logic       wr_lvl_ff;
   logic       rd_lvl_ff;
   logic       sel_lvl_ff;
   logic [7:0] data_s0_ff;
   logic [7:0] data_s1_ff;
   logic [7:0] data_s2_ff;
   logic [7:0] data_ff;
   logic [7:0] nxt_data;
   logic [2:0] nxt_wr_sh;
   logic [2:0] nxt_rd_sh;
   logic [2:0] nxt_sel_sh;
   logic       nxt_wr_lvl;
   logic       nxt_rd_lvl;
   logic       nxt_sel_lvl;

   always_comb begin
      nxt_wr_sh  = {wr_sh_ff[1:0], wr_b};
      nxt_rd_sh  = {rd_sh_ff[1:0], rd_b};
      nxt_sel_sh = {sel_sh_ff[1:0], cmd_param_select};
      nxt_wr_lvl  = (wr_sh_ff[2] == wr_sh_ff[1]) ? wr_sh_ff[2] : wr_lvl_ff;
      nxt_rd_lvl  = (rd_sh_ff[2] == rd_sh_ff[1]) ? rd_sh_ff[2] : rd_lvl_ff;
      nxt_sel_lvl = (sel_sh_ff[2] == sel_sh_ff[1]) ? sel_sh_ff[2] : sel_lvl_ff;
      nxt_data    = (data_s2_ff == data_s1_ff) ? data_s2_ff : data_ff;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_sh_ff   <= 3'h7;
         rd_sh_ff   <= 3'h7;
         sel_sh_ff  <= 3'h0;
         wr_lvl_ff  <= 1'b1;
         rd_lvl_ff  <= 1'b1;
         sel_lvl_ff <= 1'b0;
         data_s0_ff <= 8'h00;
         data_s1_ff <= 8'h00;
         data_s2_ff <= 8'h00;
         data_ff    <= 8'h00;
      end else begin
         wr_sh_ff   <= nxt_wr_sh;
         rd_sh_ff   <= nxt_rd_sh;
         sel_sh_ff  <= nxt_sel_sh;
         wr_lvl_ff  <= nxt_wr_lvl;
         rd_lvl_ff  <= nxt_rd_lvl;
         sel_lvl_ff <= nxt_sel_lvl;
         data_s0_ff <= data_in;
         data_s1_ff <= data_s0_ff;
         data_s2_ff <= data_s1_ff;
         data_ff    <= nxt_data;
      end
   end

   // Byte taken at the end of the write strobe
   assign hb.wr_stb = nxt_wr_lvl & ~wr_lvl_ff;
   assign hb.rd_stb = ~nxt_rd_lvl & rd_lvl_ff;
   assign hb.sel    = sel_lvl_ff;
   assign hb.data   = data_ff;
endmodule : host_pin_sync

// ===== supply_cmd_decode.sv
// Decodes the supply commands and holds the volume, gradient and mode state.
// Assumes command bytes come through host_pin_sync; addresses live elsewhere.
`timescale 1ns/1ns
module supply_cmd_decode (
   // Clock and reset
   input  wire logic                                clk,
   input  wire logic                                rst_b,
   // Host parallel port
   input  wire logic                                wr_b,
   input  wire logic                                rd_b,
   input  wire logic                                cmd_param_select,
   input  wire logic [7:0]                          data_in,
   output logic [7:0]                               data_out,
   output logic [7:0]                               data_oe,
   // Supply and driver control
   output logic [supply_cmd_pkg::VOL_W-1:0]         volume_bits,
   output logic [supply_cmd_pkg::GRAD_W-1:0]        gradient_bits,
   output logic                                     discharge_on,
   output logic                                     power_save,
   output logic                                     osc_run,
   output logic                                     supply_run,
   output logic                                     drivers_to_vss,
   output logic                                     blanking_out,
   // Address and mode state cleared by soft reset
   output logic [supply_cmd_pkg::COL_W-1:0]         column_addr,
   output logic [supply_cmd_pkg::PAGE_W-1:0]        page_addr,
   output logic                                     rmw_mode,
   output logic                                     test_mode,
   output logic                                     soft_reset_pulse
);
   host_byte_if hb ();

   host_pin_sync u_sync (
      .clk              (clk),
      .rst_b            (rst_b),
      .wr_b             (wr_b),
      .rd_b             (rd_b),
      .cmd_param_select (cmd_param_select),
      .data_in          (data_in),
      .hb               (hb)
   );

   supply_cmd_pkg::pend_t                   pend_ff;
   supply_cmd_pkg::pend_t                   nxt_pend;
   logic [supply_cmd_pkg::VOL_W-1:0]        vol_ff;
   logic [supply_cmd_pkg::VOL_W-1:0]        nxt_vol;
   logic [supply_cmd_pkg::GRAD_W-1:0]       grad_ff;
   logic [supply_cmd_pkg::GRAD_W-1:0]       nxt_grad;
   logic                                    dis_ff;
   logic                                    nxt_dis;
   logic                                    ps_ff;
   logic                                    nxt_ps;
   logic [supply_cmd_pkg::COL_W-1:0]        col_ff;
   logic [supply_cmd_pkg::PAGE_W-1:0]       page_ff;
   logic                                    rmw_ff;
   logic                                    test_ff;
   logic                                    srst_ff;
   logic                                    nxt_srst;
   logic [7:0]                              dout_ff;
   logic [7:0]                              nxt_dout;
   logic                                    oe_ff;
   logic                                    nxt_oe;

   // One-bit command families ignore D0 when matching
   function automatic logic is_cmd(input logic [7:0] b, input logic [7:0] code);
      is_cmd = (b[7:1] == code[7:1]);
   endfunction : is_cmd

   function automatic logic [2:0] mirror3(input logic [2:0] v);
      mirror3 = {v[0], v[1], v[2]};
   endfunction : mirror3

   function automatic logic known_cmd(input logic [7:0] b);
      known_cmd = (b == supply_cmd_pkg::CMD_VOLUME) || (b == supply_cmd_pkg::CMD_GRAD)
         || (b == supply_cmd_pkg::CMD_STATUS) || (b == supply_cmd_pkg::CMD_RESET)
         || is_cmd(b, supply_cmd_pkg::CMD_DISCH) || is_cmd(b, supply_cmd_pkg::CMD_PSAVE);
   endfunction : known_cmd

   logic cmd_wr;
   logic par_wr;
   // Host port is never gated by power save
   assign cmd_wr = hb.wr_stb & ~hb.sel;
   assign par_wr = hb.wr_stb &  hb.sel;

   always_comb begin
      nxt_pend = pend_ff;
      nxt_vol  = vol_ff;
      nxt_grad = grad_ff;
      nxt_dis  = dis_ff;
      nxt_ps   = ps_ff;
      nxt_srst = 1'b0;
      nxt_dout = dout_ff;
      nxt_oe   = oe_ff;
      if (cmd_wr) begin
         nxt_pend = supply_cmd_pkg::PEND_NONE;
         if (hb.data == supply_cmd_pkg::CMD_VOLUME) begin
            nxt_pend = supply_cmd_pkg::PEND_VOLUME;
         end else if (hb.data == supply_cmd_pkg::CMD_GRAD) begin
            nxt_pend = supply_cmd_pkg::PEND_GRAD;
         end else if (hb.data == supply_cmd_pkg::CMD_STATUS) begin
            nxt_pend = supply_cmd_pkg::PEND_STATUS;
         end else if (hb.data == supply_cmd_pkg::CMD_RESET) begin
            nxt_srst = 1'b1;
         end else if (is_cmd(hb.data, supply_cmd_pkg::CMD_DISCH)) begin
            nxt_dis = hb.data[0];
         end else if (is_cmd(hb.data, supply_cmd_pkg::CMD_PSAVE)) begin
            nxt_ps = hb.data[0];
         end
         // Other codes change no setting but still clear any pending parameter or status read
      end else if (par_wr) begin
         case (pend_ff)
            supply_cmd_pkg::PEND_VOLUME: begin
               nxt_vol  = hb.data[supply_cmd_pkg::VOL_W-1:0];
               nxt_pend = supply_cmd_pkg::PEND_NONE;
            end
            supply_cmd_pkg::PEND_GRAD: begin
               nxt_grad = hb.data[supply_cmd_pkg::GRAD_W-1:0];
               nxt_pend = supply_cmd_pkg::PEND_NONE;
            end
            default: begin
            end
         endcase
      end
      if (hb.rd_stb && pend_ff == supply_cmd_pkg::PEND_STATUS) begin
         nxt_dout = {5'h00, mirror3(grad_ff)};
         nxt_oe   = 1'b1;
      end else if (hb.rd_stb) begin
         nxt_dout = supply_cmd_pkg::RD_IDLE;
         nxt_oe   = 1'b1;
      end else if (cmd_wr || par_wr) begin
         nxt_oe   = 1'b0;
      end
   end

   // Hardware reset pin is the only full initialisation
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_ff <= supply_cmd_pkg::PEND_NONE;
         vol_ff  <= supply_cmd_pkg::VOL_RST;
         grad_ff <= supply_cmd_pkg::GRAD_RST;
         dis_ff  <= 1'b0;
         ps_ff   <= 1'b0;
         srst_ff <= 1'b0;
         dout_ff <= supply_cmd_pkg::RD_IDLE;
         oe_ff   <= 1'b0;
      end else begin
         pend_ff <= nxt_pend;
         vol_ff  <= nxt_vol;
         grad_ff <= nxt_grad;
         dis_ff  <= nxt_dis;
         ps_ff   <= nxt_ps;
         srst_ff <= nxt_srst;
         dout_ff <= nxt_dout;
         oe_ff   <= nxt_oe;
      end
   end

   // Address state: soft reset clears only these, volume and gradient stay
   logic [supply_cmd_pkg::COL_W-1:0]  nxt_col;
   logic [supply_cmd_pkg::PAGE_W-1:0] nxt_page;
   logic                              nxt_rmw;
   logic                              nxt_test;
   always_comb begin
      nxt_col  = col_ff;
      nxt_page = page_ff;
      nxt_rmw  = rmw_ff;
      nxt_test = test_ff;
      if (srst_ff) begin
         nxt_col  = '0;
         nxt_page = '0;
         nxt_rmw  = 1'b0;
         nxt_test = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         col_ff  <= '0;
         page_ff <= '0;
         rmw_ff  <= 1'b0;
         test_ff <= 1'b0;
      end else begin
         col_ff  <= nxt_col;
         page_ff <= nxt_page;
         rmw_ff  <= nxt_rmw;
         test_ff <= nxt_test;
      end
   end

   // Power-save view; settings registers are untouched so exit restores them
   logic ps_out_ff;
   logic blank_ff;
   logic osc_ff;
   logic sup_ff;
   logic nxt_ps_out;
   logic nxt_blank;
   logic nxt_osc;
   logic nxt_sup;
   always_comb begin
      nxt_ps_out = ps_ff;
      nxt_blank  = ~ps_ff;
      nxt_osc    = ~ps_ff;
      nxt_sup    = ~ps_ff;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ps_out_ff <= 1'b0;
         blank_ff  <= 1'b1;
         osc_ff    <= 1'b1;
         sup_ff    <= 1'b1;
      end else begin
         ps_out_ff <= nxt_ps_out;
         blank_ff  <= nxt_blank;
         osc_ff    <= nxt_osc;
         sup_ff    <= nxt_sup;
      end
   end

   assign volume_bits      = vol_ff;
   assign gradient_bits    = grad_ff;
   assign discharge_on     = dis_ff;
   assign power_save       = ps_out_ff;
   assign osc_run          = osc_ff;
   assign supply_run       = sup_ff;
   assign drivers_to_vss   = ps_out_ff;
   assign blanking_out     = blank_ff;
   assign column_addr      = col_ff;
   assign page_addr        = page_ff;
   assign rmw_mode         = rmw_ff;
   assign test_mode        = test_ff;
   assign soft_reset_pulse = srst_ff;
   assign data_out         = dout_ff;
   assign data_oe          = {8{oe_ff}};

   // Assertions
   property p_vol_load;
      @(posedge clk) disable iff (!rst_b)
      (par_wr && pend_ff == supply_cmd_pkg::PEND_VOLUME)
         |=> (vol_ff == $past(hb.data[6:0]) && pend_ff == supply_cmd_pkg::PEND_NONE);
   endproperty
   a_vol_load: assert property (p_vol_load) else $error("volume not loaded");

   property p_vol_stable;
      @(posedge clk) disable iff (!rst_b)
      !(par_wr && pend_ff == supply_cmd_pkg::PEND_VOLUME) |=> $stable(vol_ff);
   endproperty
   a_vol_stable: assert property (p_vol_stable) else $error("volume changed");

   property p_psave;
      @(posedge clk) disable iff (!rst_b)
      (cmd_wr && is_cmd(hb.data, supply_cmd_pkg::CMD_PSAVE))
         |=> ##1 (power_save == $past(hb.data[0], 2) && blanking_out == !power_save);
   endproperty
   a_psave: assert property (p_psave) else $error("power save wrong");

   property p_disch;
      @(posedge clk) disable iff (!rst_b)
      (cmd_wr && is_cmd(hb.data, supply_cmd_pkg::CMD_DISCH)) |=> dis_ff == $past(hb.data[0]);
   endproperty
   a_disch: assert property (p_disch) else $error("discharge wrong");

   property p_grad;
      @(posedge clk) disable iff (!rst_b)
      (par_wr && pend_ff == supply_cmd_pkg::PEND_GRAD) |=> grad_ff == $past(hb.data[2:0]);
   endproperty
   a_grad: assert property (p_grad) else $error("gradient wrong");

   property p_status;
      @(posedge clk) disable iff (!rst_b)
      (hb.rd_stb && pend_ff == supply_cmd_pkg::PEND_STATUS)
         |=> data_out[2:0] == {grad_ff[0], grad_ff[1], grad_ff[2]} && data_oe[0];
   endproperty
   a_status: assert property (p_status) else $error("status mismatch");

   property p_srst;
      @(posedge clk) disable iff (!rst_b)
      (cmd_wr && hb.data == supply_cmd_pkg::CMD_RESET)
         |=> ##1 (col_ff == '0 && page_ff == '0 && !rmw_ff && !test_ff && $stable(vol_ff));
   endproperty
   a_srst: assert property (p_srst) else $error("soft reset wrong");

   property p_vss;
      @(posedge clk) disable iff (!rst_b)
      ps_ff |=> (drivers_to_vss && !osc_run && !supply_run);
   endproperty
   a_vss: assert property (p_vss) else $error("drivers not at ground");

   property p_ps_keep;
      @(posedge clk) disable iff (!rst_b)
      (cmd_wr && is_cmd(hb.data, supply_cmd_pkg::CMD_PSAVE))
         |=> ($stable(vol_ff) && $stable(grad_ff) && $stable(dis_ff));
   endproperty
   a_ps_keep: assert property (p_ps_keep) else $error("settings moved by power save");

   property p_unknown;
      @(posedge clk) disable iff (!rst_b)
      (cmd_wr && !known_cmd(hb.data))
         |=> ($stable(vol_ff) && $stable(grad_ff) && $stable(dis_ff)
              && $stable(ps_ff) && !srst_ff);
   endproperty
   a_unknown: assert property (p_unknown) else $error("unknown command changed state");

   property p_rd_idle;
      @(posedge clk) disable iff (!rst_b)
      (hb.rd_stb && pend_ff != supply_cmd_pkg::PEND_STATUS)
         |=> (data_out == supply_cmd_pkg::RD_IDLE && data_oe[0]);
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("idle read wrong");

   property p_rd_ps;
      @(posedge clk) disable iff (!rst_b)
      (hb.rd_stb && ps_ff) |=> data_oe[0];
   endproperty
   a_rd_ps: assert property (p_rd_ps) else $error("read refused in power save");

   c_vol:    cover property (@(posedge clk) par_wr && pend_ff == supply_cmd_pkg::PEND_VOLUME);
   c_ps:     cover property (@(posedge clk) $rose(power_save) ##[1:500] $fell(power_save));
   c_status: cover property (@(posedge clk) hb.rd_stb && pend_ff == supply_cmd_pkg::PEND_STATUS);
   c_srst:   cover property (@(posedge clk) srst_ff);
   c_rd_ps:  cover property (@(posedge clk) hb.rd_stb && ps_ff);
endmodule : supply_cmd_decode

// ===== supply_cmd_pkg.sv
// Constants for the LCD supply command decoder.
// Assumes a single 100 MHz clock domain; host pins are asynchronous.
package supply_cmd_pkg;
   localparam int           VOL_W        = 7;
   localparam int           GRAD_W       = 3;
   localparam int           COL_W        = 8;
   localparam int           PAGE_W       = 5;
   localparam logic [7:0]   CMD_VOLUME   = 8'h81;
   localparam logic [7:0]   CMD_DISCH    = 8'hea;
   localparam logic [7:0]   CMD_PSAVE    = 8'ha8;
   localparam logic [7:0]   CMD_GRAD     = 8'h4e;
   localparam logic [7:0]   CMD_STATUS   = 8'h8e;
   localparam logic [7:0]   CMD_RESET    = 8'he2;
   localparam logic [6:0]   MASK_ONE_BIT = 7'h7f;
   localparam logic [VOL_W-1:0]  VOL_RST  = 7'h00;
   localparam logic [GRAD_W-1:0] GRAD_RST = 3'h0;
   localparam logic [7:0]   RD_IDLE      = 8'h00;

   typedef enum logic [1:0] {
      PEND_NONE,
      PEND_VOLUME,
      PEND_GRAD,
      PEND_STATUS
   } pend_t;
endpackage : supply_cmd_pkg

// ===== tb_lcd_supply_control_commands.sv
// Self-checking bench for the supply command decoder.
// Assumes host_model drives the host port and reset is from the hardware pin.
`timescale 1ns/1ns
module tb_lcd_supply_control_commands;
   typedef struct {
      logic [7:0] cmd;
      logic       two;
      logic [7:0] par;
      logic [6:0] vol;
      logic [2:0] grad;
      logic       dis;
      logic       ps;
   } row_t;

   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       wr_b, rd_b, cmd_param_select;
   logic [7:0] data_in, data_out, data_oe, rd_v, rd_oe;
   logic [6:0] volume_bits;
   logic [2:0] gradient_bits;
   logic       discharge_on, power_save, osc_run, supply_run, drivers_to_vss, blanking_out;
   logic [7:0] column_addr;
   logic [4:0] page_addr;
   logic       rmw_mode, test_mode, soft_reset_pulse;
   int         err_count = 0;
   int         n_compared = 0;
   int         cycles = 0;
   int         n_soft = 0;
   row_t       rows [9] = '{
      '{8'h81, 1'b1, 8'hff, 7'h7f, 3'h0, 1'b0, 1'b0},
      '{8'h81, 1'b1, 8'h80, 7'h00, 3'h0, 1'b0, 1'b0},
      '{8'h81, 1'b1, 8'h2a, 7'h2a, 3'h0, 1'b0, 1'b0},
      '{8'h4e, 1'b1, 8'hfd, 7'h2a, 3'h5, 1'b0, 1'b0},
      '{8'heb, 1'b0, 8'h00, 7'h2a, 3'h5, 1'b1, 1'b0},
      '{8'h00, 1'b0, 8'h00, 7'h2a, 3'h5, 1'b1, 1'b0},
      '{8'hea, 1'b0, 8'h00, 7'h2a, 3'h5, 1'b0, 1'b0},
      '{8'ha9, 1'b0, 8'h00, 7'h2a, 3'h5, 1'b0, 1'b1},
      '{8'ha8, 1'b0, 8'h00, 7'h2a, 3'h5, 1'b0, 1'b0}};

   always #5 clk = ~clk;

   supply_cmd_decode i_dut (
      .clk(clk), .rst_b(rst_b), .wr_b(wr_b), .rd_b(rd_b),
      .cmd_param_select(cmd_param_select), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .volume_bits(volume_bits), .gradient_bits(gradient_bits),
      .discharge_on(discharge_on), .power_save(power_save), .osc_run(osc_run),
      .supply_run(supply_run), .drivers_to_vss(drivers_to_vss),
      .blanking_out(blanking_out), .column_addr(column_addr), .page_addr(page_addr),
      .rmw_mode(rmw_mode), .test_mode(test_mode), .soft_reset_pulse(soft_reset_pulse)
   );

   host_model i_host (
      .clk(clk), .data_out(data_out), .data_oe(data_oe), .wr_b(wr_b), .rd_b(rd_b),
      .cmd_param_select(cmd_param_select), .data_in(data_in)
   );

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("Compared %0d, errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // Cut a hang short
   always @(posedge clk) begin
      cycles++;
      if (soft_reset_pulse === 1'b1) n_soft++;
      if (cycles == 30000) begin
         err_count++;
         report_and_stop();
      end
   end

   task automatic hw_reset();
      #1 rst_b = 1'b0;
      repeat (12) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (2) @(posedge clk);
   endtask : hw_reset

   // Expected status byte: stored P0 lands where P2 sits
   function automatic logic [7:0] mirror(input logic [2:0] g);
      return {5'h00, g[0], g[1], g[2]};
   endfunction : mirror

   initial begin
      hw_reset();
      chk({5'h00, gradient_bits}, 8'h00);
      chk({7'h00, blanking_out}, 8'h01);
      chk(data_oe, 8'h00);
      foreach (rows[i]) begin
         i_host.put(1'b0, rows[i].cmd);
         if (rows[i].two) i_host.put(1'b1, rows[i].par);
         repeat (2) @(posedge clk);
         chk({1'b0, volume_bits}, {1'b0, rows[i].vol});
         chk({5'h00, gradient_bits}, {5'h00, rows[i].grad});
         chk({7'h00, discharge_on}, {7'h00, rows[i].dis});
         chk({7'h00, power_save}, {7'h00, rows[i].ps});
         chk({7'h00, blanking_out}, {7'h00, ~rows[i].ps});
         chk({6'h00, osc_run, supply_run}, {6'h00, {2{~rows[i].ps}}});
         chk({7'h00, drivers_to_vss}, {7'h00, rows[i].ps});
      end
      // Parameter with nothing pending is dropped
      i_host.put(1'b0, 8'h81);
      i_host.put(1'b1, 8'h33);
      i_host.put(1'b1, 8'h44);
      repeat (2) @(posedge clk);
      chk({1'b0, volume_bits}, 8'h33);
      // Status read of two gradient codes, read twice each
      for (int g = 1; g < 8; g += 5) begin
         i_host.put(1'b0, 8'h4e);
         i_host.put(1'b1, 8'(g));
         i_host.put(1'b0, 8'h8e);
         repeat (2) begin
            i_host.get(rd_v, rd_oe);
            chk(rd_v, mirror(3'(g)));
            chk(rd_oe, 8'hff);
         end
      end
      // Status read still answers in power save, and exit restores the run state
      i_host.put(1'b0, 8'ha9);
      i_host.put(1'b0, 8'h8e);
      i_host.get(rd_v, rd_oe);
      chk(rd_v, mirror(3'h6));
      chk(rd_oe, 8'hff);
      chk({7'h00, power_save}, 8'h01);
      i_host.put(1'b0, 8'ha8);
      chk({7'h00, power_save}, 8'h00);
      chk({6'h00, osc_run, supply_run}, 8'h03);
      chk(data_oe, 8'h00);
      // Soft reset keeps settings and fires once after its byte
      chk(8'(n_soft), 8'h00);
      i_host.put(1'b0, 8'he2);
      repeat (2) @(posedge clk);
      chk(8'(n_soft), 8'h01);
      chk(column_addr, 8'h00);
      chk({3'h0, page_addr}, 8'h00);
      chk({6'h00, rmw_mode, test_mode}, 8'h00);
      chk({1'b0, volume_bits}, 8'h33);
      chk({5'h00, gradient_bits}, 8'h06);
      // A later command cancels a pending status read; idle reads give zero
      i_host.put(1'b0, 8'h8e);
      i_host.put(1'b0, 8'he3);
      i_host.get(rd_v, rd_oe);
      chk(rd_v, 8'h00);
      chk(rd_oe, 8'hff);
      i_host.put(1'b0, 8'he3);
      chk(data_oe, 8'h00);
      chk(8'(n_soft), 8'h01);
      chk({5'h00, gradient_bits}, 8'h06);
      // Hardware reset in power save brings everything back
      i_host.put(1'b0, 8'ha9);
      chk({7'h00, blanking_out}, 8'h00);
      hw_reset();
      chk({5'h00, gradient_bits}, 8'h00);
      chk({7'h00, power_save}, 8'h00);
      chk({7'h00, blanking_out}, 8'h01);
      report_and_stop();
   end
endmodule : tb_lcd_supply_control_commands
